// ===== sim/quantity_source_model.sv
`timescale 1ns/100ps
// far side: command pulse source, position loop and motor feedback
module quantity_source_model (
	input wire logic mclk_in,
	input wire logic [1:0] which_in,
	input wire logic [15:0] value_in,
	input wire logic pin_in,
	output logic [15:0] command_frequency_out,
	output logic [15:0] position_deviation_out,
	output logic [15:0] motor_speed_out,
	output logic digital_input_port_out
);
	// quantities not under test sit at zero, like a stopped axis
	always_ff @(posedge mclk_in) begin
		command_frequency_out <= (which_in == 2'h0) ? value_in : 16'h0000;
		position_deviation_out <= (which_in == 2'h1) ? value_in : 16'h0000;
		motor_speed_out <= (which_in == 2'h2) ? value_in : 16'h0000;
		digital_input_port_out <= pin_in;
	end
endmodule

// ===== sim/servo_gain_group_switcher_bench.sv
`timescale 1ns/100ps
module servo_gain_group_switcher_bench;
	logic mclk_in = 1'b0, reset_n_in = 1'b0, pin = 1'b0;
	logic [2:0] sel = 3'h0;
	logic [1:0] which = 2'h3;
	logic [15:0] value = 16'h0000, integral_second = 16'h4000, d0;
	logic [15:0] sg2 = 16'h2000, tf2 = 16'h4000, pg2 = 16'h5000;
	logic [14:0] lvl = gain_switch_pkg::LEVEL_RESET, hyst = gain_switch_pkg::HYSTERESIS_RESET;
	logic [11:0] qdelay = 12'h003, rtime = 12'h002;
	logic [15:0] cf, pd, ms, sg, si, tf, pg;
	logic di, integral_disable_out, second_group_out, ramping_out;
	int mismatches = 0, check_count = 0, n;
	initial forever #25 mclk_in = ~mclk_in;
	quantity_source_model u_quantity_source_model (.mclk_in(mclk_in), .which_in(which), .value_in(value),
		.pin_in(pin), .command_frequency_out(cf), .position_deviation_out(pd), .motor_speed_out(ms),
		.digital_input_port_out(di));
	// 1 ms shrunk to 4 cycles: qualify 3 ms = 12 cycles, ramp 2 ms = 8 cycles
	servo_gain_group_switcher #(.MS_CYCLES(16'h0004)) u_servo_gain_group_switcher (.mclk_in(mclk_in),
		.reset_n_in(reset_n_in), .gain_switch_select_in(sel),
		.gain_switch_level_in(lvl), .gain_switch_hysteresis_in(hyst),
		.gain_switch_qualify_delay_in(qdelay), .gain_switch_ramp_time_in(rtime),
		.speed_gain_first_in(16'h1000), .speed_integral_first_in(16'h2000), .torque_filter_first_in(16'h3000),
		.position_gain_first_in(16'h4000), .speed_gain_second_in(sg2),
		.speed_integral_second_in(integral_second), .torque_filter_second_in(tf2),
		.position_gain_second_in(pg2), .command_frequency_in(cf), .position_deviation_in(pd),
		.motor_speed_in(ms), .digital_input_port_in(di), .speed_gain_out(sg), .speed_integral_out(si),
		.torque_filter_out(tf), .position_gain_out(pg), .integral_disable_out(integral_disable_out),
		.second_group_out(second_group_out), .ramping_out(ramping_out));
	////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// bounded: a hung switch ends the run as a failure
	task automatic settle(input logic second);
		n = 0;
		while (!(second_group_out === second && ramping_out === 1'b0) && n < 300) begin
			@(negedge mclk_in);
			n++;
		end
		if (n >= 300) begin
			mismatches++;
			$display("wrong value settle expected %h seen %h", second, second_group_out);
			summarize();
		end
	endtask
	task automatic wait_ramp();
		n = 0;
		while (ramping_out !== 1'b1 && n < 100) begin
			@(negedge mclk_in);
			n++;
		end
		if (ramping_out !== 1'b1) begin
			mismatches++;
			$display("wrong value ramp_start expected 1 seen %b", ramping_out);
			summarize();
		end
	endtask
	task automatic check_group(input logic second);
		check("speed_gain", sg, second ? 16'h2000 : 16'h1000);
		check("speed_integral", si, second ? integral_second : 16'h2000);
		check("torque_filter", tf, second ? 16'h4000 : 16'h3000);
		check("position_gain", pg, second ? 16'h5000 : 16'h4000);
		check("second_group", {15'h0, second_group_out}, {15'h0, second});
	endtask
	task automatic hold_check(input logic second);
		repeat (60) @(negedge mclk_in);
		check("held_group", {15'h0, second_group_out}, {15'h0, second});
		check("held_ramp", {15'h0, ramping_out}, 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge mclk_in);
		reset_n_in = 1'b1;
		repeat (4) @(negedge mclk_in);
		check_group(1'b0);
		$display("test reset done");
		sel = 3'h1;
		wait_ramp();
		repeat (4) @(negedge mclk_in);
		// same fraction everywhere; the integral span is twice the others
		d0 = sg - 16'h1000;
		check("ramp_partial", {15'h0, (d0 > 16'h0000 && d0 < 16'h1000)}, 16'h0001);
		check("ramp_integral", si - 16'h2000, {d0[14:0], 1'b0});
		check("ramp_filter", tf - 16'h3000, d0);
		check("ramp_position", pg - 16'h4000, d0);
		settle(1'b1);
		check_group(1'b1);
		sel = 3'h0;
		settle(1'b0);
		check_group(1'b0);
		$display("test fixed modes done");
		sel = 3'h2;
		pin = 1'b1;
		settle(1'b1);
		check_group(1'b1);
		pin = 1'b0;
		settle(1'b0);
		check_group(1'b0);
		$display("test pin mode done");
		for (int k = 0; k < 3; k++) begin
			sel = 3'(3 + k);
			which = 2'(k);
			value = 16'h0064;
			hold_check(1'b0);
			value = 16'h0065;
			settle(1'b1);
			check_group(1'b1);
			value = 16'h0061;
			hold_check(1'b1);
			value = 16'h005e;
			settle(1'b0);
			check_group(1'b0);
		end
		$display("test level modes done");
		sel = 3'h3;
		which = 2'h0;
		value = 16'h00c8;
		repeat (4) @(negedge mclk_in);
		value = 16'h0000;
		hold_check(1'b0);
		$display("test glitch done");
		lvl = 15'h00c8;
		hyst = 15'h000a;
		sel = 3'h5;
		which = 2'h2;
		value = 16'h00c8;
		hold_check(1'b0);
		value = 16'h00c9;
		settle(1'b1);
		check_group(1'b1);
		value = 16'h00be;
		hold_check(1'b1);
		value = 16'h00bd;
		settle(1'b0);
		check_group(1'b0);
		$display("test level change done");
		// long ramp so the return order lands mid-ramp
		rtime = 12'h00a;
		sel = 3'h1;
		wait_ramp();
		sel = 3'h0;
		settle(1'b0);
		check_group(1'b0);
		$display("test reversal done");
		integral_second = gain_switch_pkg::INTEGRAL_OFF;
		sel = 3'h1;
		settle(1'b1);
		check("integral_off", {15'h0, integral_disable_out}, 16'h0001);
		sel = 3'h0;
		settle(1'b0);
		check("integral_on", {15'h0, integral_disable_out}, 16'h0000);
		$display("test integral cancel done");
		sel = 3'h1;
		settle(1'b1);
		sel = 3'h7;
		settle(1'b0);
		check_group(1'b0);
		// zero delay and zero ramp: select, want, target, state, settled, outputs
		qdelay = 12'h000;
		rtime = 12'h000;
		sel = 3'h1;
		repeat (5) @(negedge mclk_in);
		check("fast_group", {15'h0, second_group_out}, 16'h0001);
		check("fast_speed_gain", sg, 16'h2000);
		$display("test spare code and zero times done");
		summarize();
	end
endmodule

// ===== src/gain_switch_pkg.sv
package gain_switch_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int MS_PER_S = 1000;
	localparam logic [15:0] MS_CYCLES = 16'(CLK_HZ / MS_PER_S);
	localparam int VALUE_W = 16;
	localparam int LEVEL_W = 15;
	localparam int TIME_W = 12;
	localparam logic [2:0] SELECT_RESET = 3'h0;
	localparam logic [LEVEL_W-1:0] LEVEL_RESET = 15'h0064;
	localparam logic [LEVEL_W-1:0] HYSTERESIS_RESET = 15'h0005;
	localparam logic [TIME_W-1:0] QUALIFY_DELAY_RESET = 12'h005;
	localparam logic [TIME_W-1:0] RAMP_TIME_RESET = 12'h005;
	localparam logic [TIME_W-1:0] TIME_MAX = 12'hbb8;
	localparam logic [VALUE_W-1:0] INTEGRAL_OFF = 16'h2710;
	typedef enum logic [2:0] {
		SEL_FIXED_FIRST = 3'b000,
		SEL_FIXED_SECOND = 3'b001,
		SEL_INPUT = 3'b010,
		SEL_FREQUENCY = 3'b011,
		SEL_DEVIATION = 3'b100,
		SEL_SPEED = 3'b101
	} select_t;
	typedef enum logic [1:0] {
		ST_FIRST = 2'b00,
		ST_TO_SECOND = 2'b01,
		ST_SECOND = 2'b10,
		ST_TO_FIRST = 2'b11
	} ramp_state_t;
endpackage

// ===== src/servo_gain_group_switcher.sv
// Behaviour
// [R1] Selection 0 always uses the first gain group.
// [R2] Selection 1 always uses the second gain group.
// [R3] Selection 2 follows the gain select input: off is first group, on is second group.
// [R4] Selection 3 picks the second group when command pulse frequency exceeds the level.
// [R5] Selection 4 picks the second group when position deviation exceeds the level.
// [R6] Selection 5 picks the second group when motor speed exceeds the level.
// [R7] In condition selections the first group returns once the condition no longer holds.
// [R8] A change of condition must persist for the qualify delay (0 to 3000 ms) before acting.
// [R9] A switch moves each active value linearly to the target over the ramp time (0 to 3000 ms).
// [R10] All four values ramp together over the same interval.
// [R11] The level compare has a hysteresis band, 0 to 32767.
// [R12] The switching level is 0 to 32767 and is compared to the selected quantity.
// [R13] Each group holds speed gain, speed integral, torque filter and position gain.
// [R14] A second-group integral equal to its maximum removes the integral term.
// [R15] In the second group the condition drops only below level minus hysteresis.
// [R16] The ramp updates interpolated values every cycle by the elapsed fraction.
`timescale 1ns/100ps
module servo_gain_group_switcher #(
	parameter int VALUE_W = gain_switch_pkg::VALUE_W,
	parameter logic [15:0] MS_CYCLES = gain_switch_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic reset_n_in,
	// configuration
	input wire logic [2:0] gain_switch_select_in,
	input wire logic [14:0] gain_switch_level_in,
	input wire logic [14:0] gain_switch_hysteresis_in,
	input wire logic [11:0] gain_switch_qualify_delay_in,
	input wire logic [11:0] gain_switch_ramp_time_in,
	// first group
	input wire logic [VALUE_W-1:0] speed_gain_first_in,
	input wire logic [VALUE_W-1:0] speed_integral_first_in,
	input wire logic [VALUE_W-1:0] torque_filter_first_in,
	input wire logic [VALUE_W-1:0] position_gain_first_in,
	// second group
	input wire logic [VALUE_W-1:0] speed_gain_second_in,
	input wire logic [VALUE_W-1:0] speed_integral_second_in,
	input wire logic [VALUE_W-1:0] torque_filter_second_in,
	input wire logic [VALUE_W-1:0] position_gain_second_in,
	// measured quantities, same clock
	input wire logic [15:0] command_frequency_in,
	input wire logic [15:0] position_deviation_in,
	input wire logic [15:0] motor_speed_in,
	// pin
	input wire logic digital_input_port_in,
	// active values
	output logic [VALUE_W-1:0] speed_gain_out,
	output logic [VALUE_W-1:0] speed_integral_out,
	output logic [VALUE_W-1:0] torque_filter_out,
	output logic [VALUE_W-1:0] position_gain_out,
	output logic integral_disable_out,
	output logic second_group_out,
	output logic ramping_out
);

////////////////////////////////////////////////////////////////////////////////
	logic di_meta_q;
	logic di_sync_q;
	logic want_q;
	logic want_d;
	logic target_q;
	logic [15:0] ms_div_q;
	logic ms_tick;
	logic [11:0] qual_ms_q;
	logic settled;
	logic reversed;
	logic [VALUE_W-1:0] settled_v [4];
	logic [27:0] ramp_cyc_q;
	logic [27:0] ramp_total;
	gain_switch_pkg::ramp_state_t state_q;
	logic [VALUE_W-1:0] from_q [4];
	logic [VALUE_W-1:0] to_v [4];
	logic [VALUE_W-1:0] first_v [4];
	logic [VALUE_W-1:0] second_v [4];
	logic [VALUE_W-1:0] val_q [4];
	logic [VALUE_W-1:0] interp_v [4];
	logic [15:0] quantity;
	logic [15:0] level_w;
	logic [15:0] low_w;
	logic over_level;
	logic cond;
	logic ramp_done;

	// linear blend, wide product so 3000 ms at 20 MHz fits
	function automatic logic [VALUE_W-1:0] blend(input logic [VALUE_W-1:0] a, input logic [VALUE_W-1:0] b,
			input logic [27:0] n, input logic [27:0] d);
		logic signed [VALUE_W+1:0] diff;
		logic signed [VALUE_W+31:0] prod;
		logic signed [VALUE_W+31:0] q;
		diff = $signed({2'b00, b}) - $signed({2'b00, a});
		prod = diff * $signed({4'h0, n});
		q = prod / $signed({4'h0, d});
		blend = VALUE_W'($signed({2'b00, a}) + q);
	endfunction

////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_in) begin
		di_meta_q <= digital_input_port_in;
		di_sync_q <= di_meta_q;
	end

	assign first_v[0] = speed_gain_first_in;
	assign first_v[1] = speed_integral_first_in;
	assign first_v[2] = torque_filter_first_in;
	assign first_v[3] = position_gain_first_in;
	assign second_v[0] = speed_gain_second_in;
	assign second_v[1] = speed_integral_second_in;
	assign second_v[2] = torque_filter_second_in;
	assign second_v[3] = position_gain_second_in; // R13

	assign quantity = (gain_switch_select_in == gain_switch_pkg::SEL_FREQUENCY) ? command_frequency_in : // R4
		(gain_switch_select_in == gain_switch_pkg::SEL_DEVIATION) ? position_deviation_in : // R5
		motor_speed_in; // R6
	assign level_w = {1'b0, gain_switch_level_in}; // R12
	// clamp at zero so a wide band never wraps
	assign low_w = (gain_switch_hysteresis_in > gain_switch_level_in) ? 16'h0000 :
		16'(gain_switch_level_in - gain_switch_hysteresis_in); // R11
	// hysteresis: stay second until below level minus band
	assign over_level = want_q ? !(quantity < low_w) : (quantity > level_w); // R15 R7

	always_comb begin
		case (gain_switch_select_in)
			gain_switch_pkg::SEL_FIXED_FIRST: cond = 1'b0; // R1
			gain_switch_pkg::SEL_FIXED_SECOND: cond = 1'b1; // R2
			gain_switch_pkg::SEL_INPUT: cond = di_sync_q; // R3
			gain_switch_pkg::SEL_FREQUENCY,
			gain_switch_pkg::SEL_DEVIATION,
			gain_switch_pkg::SEL_SPEED: cond = over_level;
			default: cond = 1'b0;
		endcase
	end

	assign ms_tick = (ms_div_q == MS_CYCLES - 16'h0001);
	assign want_d = cond;

////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			ms_div_q <= 16'h0000;
		end else if (ms_tick) begin
			ms_div_q <= 16'h0000;
		end else begin
			ms_div_q <= ms_div_q + 16'h0001;
		end
	end

	// raw condition level, compared against committed target
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			want_q <= 1'b0;
		end else begin
			want_q <= want_d;
		end
	end

	// qualify: any return to the committed state restarts the count
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			qual_ms_q <= 12'h000;
			target_q <= 1'b0;
		end else if (want_q == target_q) begin
			qual_ms_q <= 12'h000; // R8
		end else if (qual_ms_q >= gain_switch_qualify_delay_in) begin
			target_q <= want_q; // R8
			qual_ms_q <= 12'h000;
		end else if (ms_tick) begin
			qual_ms_q <= qual_ms_q + 12'h001;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	assign ramp_total = 28'(gain_switch_ramp_time_in) * 28'(MS_CYCLES);
	assign ramp_done = (ramp_cyc_q >= ramp_total);
	assign settled = (state_q == gain_switch_pkg::ST_FIRST || state_q == gain_switch_pkg::ST_SECOND);
	// target flipped mid-ramp: freeze values for a cycle while the start point is recaptured
	assign reversed = !settled && (target_q != (state_q == gain_switch_pkg::ST_TO_SECOND));
	generate
		for (genvar i = 0; i < 4; i++) begin : g_val
			assign to_v[i] = target_q ? second_v[i] : first_v[i];
			// settled values follow the group in force, not the new target, so nothing jumps early
			assign settled_v[i] = (state_q == gain_switch_pkg::ST_SECOND) ? second_v[i] : first_v[i];
			assign interp_v[i] = ramp_done ? to_v[i] : blend(from_q[i], to_v[i], ramp_cyc_q, ramp_total); // R16 R9
		end
	endgenerate

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			state_q <= gain_switch_pkg::ST_FIRST;
			ramp_cyc_q <= 28'h0000000;
		end else begin
			case (state_q)
				gain_switch_pkg::ST_FIRST,
				gain_switch_pkg::ST_SECOND: begin
					ramp_cyc_q <= 28'h0000000;
					if (target_q != (state_q == gain_switch_pkg::ST_SECOND)) begin
						state_q <= target_q ? gain_switch_pkg::ST_TO_SECOND : gain_switch_pkg::ST_TO_FIRST;
					end
				end
				default: begin
					if (target_q != (state_q == gain_switch_pkg::ST_TO_SECOND)) begin
						// reversed mid-ramp: restart from where values are
						state_q <= target_q ? gain_switch_pkg::ST_TO_SECOND : gain_switch_pkg::ST_TO_FIRST;
						ramp_cyc_q <= 28'h0000000;
					end else if (ramp_done) begin
						state_q <= target_q ? gain_switch_pkg::ST_SECOND : gain_switch_pkg::ST_FIRST;
					end else begin
						ramp_cyc_q <= ramp_cyc_q + 28'h0000001; // R16
					end
				end
			endcase
		end
	end

	// all four share one counter so none moves ahead
	always_ff @(posedge mclk_in) begin
		for (int i = 0; i < 4; i++) begin
			if (!reset_n_in) begin
				from_q[i] <= '0;
				val_q[i] <= '0;
			end else begin
				val_q[i] <= settled ? settled_v[i] : (reversed ? val_q[i] : interp_v[i]); // R10
				if (settled || reversed) begin
					from_q[i] <= val_q[i];
				end
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			speed_gain_out <= '0;
			speed_integral_out <= '0;
			torque_filter_out <= '0;
			position_gain_out <= '0;
			integral_disable_out <= 1'b0;
			second_group_out <= 1'b0;
			ramping_out <= 1'b0;
		end else begin
			speed_gain_out <= val_q[0];
			speed_integral_out <= val_q[1];
			torque_filter_out <= val_q[2];
			position_gain_out <= val_q[3];
			integral_disable_out <= (val_q[1] >= VALUE_W'(gain_switch_pkg::INTEGRAL_OFF)); // R14
			second_group_out <= (state_q == gain_switch_pkg::ST_SECOND);
			ramping_out <= (state_q == gain_switch_pkg::ST_TO_SECOND || state_q == gain_switch_pkg::ST_TO_FIRST);
		end
	end

////////////////////////////////////////////////////////////////////////////////
	sequence s_first_fixed;
		gain_switch_select_in == 3'h0 && state_q == gain_switch_pkg::ST_FIRST;
	endsequence

	sequence s_ramp_end;
		!settled && !reversed && ramp_done;
	endsequence

	AST_FIXED_FIRST: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R1
		gain_switch_select_in == 3'h0 && $past(gain_switch_select_in) == 3'h0 |-> !want_q)
		else $error("fixed first selection wanting second");
	AST_FIXED_SECOND: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R2
		gain_switch_select_in == 3'h1 && $past(gain_switch_select_in) == 3'h1 |-> want_q)
		else $error("fixed second selection not wanting second");
	AST_INPUT_FOLLOW: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R3
		gain_switch_select_in == 3'h2 && $stable(gain_switch_select_in) |-> want_q == $past(di_sync_q))
		else $error("input selection not following pin");
	AST_OVER_LEVEL: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R4
		gain_switch_select_in == 3'h3 && !want_q && command_frequency_in > level_w |=> want_q)
		else $error("frequency above level not seen");
	AST_HYST_HOLD: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R15
		gain_switch_select_in == 3'h5 && want_q && motor_speed_in >= low_w |=> want_q)
		else $error("dropped inside hysteresis band");
	AST_QUALIFY: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R8
		$changed(target_q) && gain_switch_qualify_delay_in != 12'h000 |->
		$past(want_q) == target_q && $past(want_q, 2) == target_q)
		else $error("target changed without persisting condition");
	AST_STAY_FIXED: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R1
		s_first_fixed ##1 gain_switch_select_in == 3'h0 |-> state_q == gain_switch_pkg::ST_FIRST)
		else $error("left first group under fixed selection");
	AST_RAMP_BOUND: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R9
		ramping_out && $stable(target_q) |-> ramp_cyc_q <= ramp_total)
		else $error("ramp counter overran switching time");
	AST_INTEGRAL_OFF: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R14
		val_q[1] == gain_switch_pkg::INTEGRAL_OFF |=> integral_disable_out)
		else $error("integral not removed at maximum");
	AST_DEVIATION: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R5
		gain_switch_select_in == 3'h4 && !want_q && position_deviation_in > level_w |=> want_q)
		else $error("deviation above level not seen");
	AST_SPEED: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R6
		gain_switch_select_in == 3'h5 && !want_q && motor_speed_in > level_w |=> want_q)
		else $error("speed above level not seen");
	AST_RETURN_FIRST: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R7
		gain_switch_select_in >= 3'h3 && gain_switch_select_in <= 3'h5 && want_q && quantity < low_w |=> !want_q)
		else $error("condition kept below the band");
	AST_SETTLED_SECOND: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R13
		state_q == gain_switch_pkg::ST_SECOND |=> val_q[3] == $past(second_v[3]))
		else $error("settled second group not showing its values");
	AST_REVERSE_HOLD: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R9
		reversed |=> val_q[1] == $past(val_q[1]))
		else $error("values jumped on a mid-ramp reversal");
	AST_RAMP_END: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R9
		s_ramp_end |=> settled)
		else $error("ramp ran past its switching time");
	AST_INTEGRAL_ON: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // R14
		val_q[1] < gain_switch_pkg::INTEGRAL_OFF |=> !integral_disable_out)
		else $error("integral removed below maximum");
endmodule
